// *** rtl/scan_opcode_decoder.sv ***
// bridge end: tap controller, 8-bit instruction register and opcode decode
// assumes: address matching outside sets selected and multicast_mode
//
// Behaviour
// - e7 inserts local ports, selects idcode
// - c5/84/c6 park ports, select idcode
// - c3 returns to address wait, idcode
// - 8e selects mode register zero
// - 82/83/85 select mode registers one-three
// - 03 selects multicast group register
// - 88 soft reset, selects idcode
// - c9 selects signature shift register
// - 0c enables signature, selects idcode
// - 8d disables signature, selects idcode
// - ce selects 32-bit clock counter
// - 0f enables counter, selects idcode
// - 90 disables counter, selects idcode
// - 07 makes bypass the data register
// - a0 selects transparent enable register zero
// - control and unknown opcodes select idcode
// - act only while selected
// - group selection keeps test output floating
`timescale 1ns/1ps
module scan_opcode_decoder (
  input wire logic sys_clk,
  input wire logic reset,
  scan_link_if.device link,
  input wire logic selected,
  input wire logic multicast_mode,
  input wire logic dr_tdo_in,
  output scan_op_pkg::dr_sel_type dr_select,
  output scan_op_pkg::action_type action,
  output logic action_pulse,
  output logic [7:0] instruction,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr,
  output logic test_reset
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic scan_op_pkg::dr_sel_type decode_dr(input logic [7:0] op);
    case (op)
      scan_op_pkg::mode_reg0_select_op: decode_dr = scan_op_pkg::dr_mode0;
      scan_op_pkg::mode_reg1_select_op: decode_dr = scan_op_pkg::dr_mode1;
      scan_op_pkg::mode_reg2_select_op: decode_dr = scan_op_pkg::dr_mode2;
      scan_op_pkg::mode_reg3_select_op: decode_dr = scan_op_pkg::dr_mode3;
      scan_op_pkg::group_reg_select_op: decode_dr = scan_op_pkg::dr_group;
      scan_op_pkg::signature_reg_select_op:
        decode_dr = scan_op_pkg::dr_signature;
      scan_op_pkg::clock_counter_select_op:
        decode_dr = scan_op_pkg::dr_counter;
      scan_op_pkg::default_bypass_op: decode_dr = scan_op_pkg::dr_bypass;
      scan_op_pkg::pass_through_port0_op:
        decode_dr = scan_op_pkg::dr_pass_through_port0_op;
      default: decode_dr = scan_op_pkg::dr_idcode;
    endcase
  endfunction : decode_dr

  function automatic scan_op_pkg::action_type decode_act(input logic [7:0] op);
    case (op)
      scan_op_pkg::insert_local_ports_op: decode_act = scan_op_pkg::act_insert;
      scan_op_pkg::park_in_reset_op: decode_act = scan_op_pkg::act_park_reset;
      scan_op_pkg::park_in_idle_op: decode_act = scan_op_pkg::act_park_idle;
      scan_op_pkg::park_in_pause_op: decode_act = scan_op_pkg::act_park_pause;
      scan_op_pkg::return_to_address_wait_op:
        decode_act = scan_op_pkg::act_goto_wait;
      scan_op_pkg::soft_reset_op: decode_act = scan_op_pkg::act_soft_reset;
      scan_op_pkg::signature_enable_op: decode_act = scan_op_pkg::act_sig_on;
      scan_op_pkg::signature_disable_op: decode_act = scan_op_pkg::act_sig_off;
      scan_op_pkg::clock_counter_enable_op: decode_act = scan_op_pkg::act_cnt_on;
      scan_op_pkg::clock_counter_disable_op:
        decode_act = scan_op_pkg::act_cnt_off;
      default: decode_act = scan_op_pkg::act_none;
    endcase
  endfunction : decode_act

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  scan_op_pkg::tap_state_type tap_q, tap_d;
  logic [7:0] ir_shift_q, ir_shift_d;
  logic [7:0] ir_q, ir_d;
  logic [31:0] id_shift_q, id_shift_d;
  logic bypass_q, bypass_d;
  scan_op_pkg::dr_sel_type sel_q, sel_d;
  scan_op_pkg::action_type act_q, act_d;
  logic pulse_q, pulse_d;
  logic tdo_q, tdo_d;
  logic oe_n_q, oe_n_d;
  logic cap_q, cap_d, sh_q, sh_d, upd_q, upd_d, rst_q, rst_d;

  always_comb begin
    tap_d = scan_op_pkg::tap_next(tap_q, link.tms);
    ir_shift_d = ir_shift_q;
    ir_d = ir_q;
    id_shift_d = id_shift_q;
    bypass_d = bypass_q;
    sel_d = sel_q;
    act_d = act_q;
    pulse_d = 1'b0;
    tdo_d = tdo_q;
    oe_n_d = 1'b1;
    case (tap_q)
      scan_op_pkg::tap_reset: begin
        ir_d = scan_op_pkg::ir_reset_value;
        sel_d = scan_op_pkg::dr_idcode;
        act_d = scan_op_pkg::act_none;
      end
      scan_op_pkg::tap_cap_ir: ir_shift_d = scan_op_pkg::ir_capture_value;
      scan_op_pkg::tap_shift_ir: begin
        tdo_d = ir_shift_q[0];
        oe_n_d = multicast_mode;
        ir_shift_d = {link.tdi, ir_shift_q[7:1]};
      end
      scan_op_pkg::tap_upd_ir: begin
        // unselected devices still latch, so address words reach matching
        ir_d = ir_shift_q;
        if (selected) begin
          sel_d = decode_dr(ir_shift_q);
          act_d = decode_act(ir_shift_q);
          pulse_d = 1'b1;
        end else begin
          sel_d = scan_op_pkg::dr_idcode;
          act_d = scan_op_pkg::act_none;
        end
      end
      scan_op_pkg::tap_cap_dr: begin
        id_shift_d = scan_op_pkg::idcode_value;
        bypass_d = 1'b0;
      end
      scan_op_pkg::tap_shift_dr: begin
        id_shift_d = {link.tdi, id_shift_q[31:1]};
        bypass_d = link.tdi;
        case (sel_q)
          scan_op_pkg::dr_idcode: tdo_d = id_shift_q[0];
          scan_op_pkg::dr_bypass: tdo_d = bypass_q;
          default: tdo_d = dr_tdo_in;
        endcase
        oe_n_d = multicast_mode;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    cap_d = (tap_d == scan_op_pkg::tap_cap_dr);
    sh_d = (tap_d == scan_op_pkg::tap_shift_dr);
    upd_d = (tap_d == scan_op_pkg::tap_upd_dr);
    rst_d = (tap_d == scan_op_pkg::tap_reset);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tap_q <= scan_op_pkg::tap_reset;
      ir_shift_q <= 8'h00;
      ir_q <= scan_op_pkg::ir_reset_value;
      id_shift_q <= 32'h00000000;
      bypass_q <= 1'b0;
      sel_q <= scan_op_pkg::dr_idcode;
      act_q <= scan_op_pkg::act_none;
      pulse_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_n_q <= 1'b1;
      cap_q <= 1'b0;
      sh_q <= 1'b0;
      upd_q <= 1'b0;
      rst_q <= 1'b1;
    end else begin
      tap_q <= tap_d;
      ir_shift_q <= ir_shift_d;
      ir_q <= ir_d;
      id_shift_q <= id_shift_d;
      bypass_q <= bypass_d;
      sel_q <= sel_d;
      act_q <= act_d;
      pulse_q <= pulse_d;
      tdo_q <= tdo_d;
      oe_n_q <= oe_n_d;
      cap_q <= cap_d;
      sh_q <= sh_d;
      upd_q <= upd_d;
      rst_q <= rst_d;
    end
  end

  assign link.tdo = tdo_q;
  assign link.tdo_oe_n = oe_n_q;
  assign dr_select = sel_q;
  assign action = act_q;
  assign action_pulse = pulse_q;
  assign instruction = ir_q;
  assign capture_dr = cap_q;
  assign shift_dr = sh_q;
  assign update_dr = upd_q;
  assign test_reset = rst_q;

endmodule : scan_opcode_decoder

// *** include/scan_op_pkg.sv ***
// opcodes, data-register selection codes and tap state codes of the bridge
// assumes: 8-bit instruction register, ieee 1149.1 tap on the bridge end
package scan_op_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ir_width = 8;
  localparam int unsigned id_width = 32;
  localparam logic [7:0] ir_reset_value = 8'haa;
  localparam logic [7:0] ir_capture_value = 8'h01;
  localparam logic [31:0] idcode_value = 32'h0a5a5001; // arbitrary value

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] idcode_op = 8'haa;
  localparam logic [7:0] insert_local_ports_op = 8'he7;
  localparam logic [7:0] park_in_reset_op = 8'hc5;
  localparam logic [7:0] park_in_idle_op = 8'h84;
  localparam logic [7:0] park_in_pause_op = 8'hc6;
  localparam logic [7:0] return_to_address_wait_op = 8'hc3;
  localparam logic [7:0] mode_reg0_select_op = 8'h8e;
  localparam logic [7:0] mode_reg1_select_op = 8'h82;
  localparam logic [7:0] mode_reg2_select_op = 8'h83;
  localparam logic [7:0] mode_reg3_select_op = 8'h85;
  localparam logic [7:0] group_reg_select_op = 8'h03;
  localparam logic [7:0] soft_reset_op = 8'h88;
  localparam logic [7:0] signature_reg_select_op = 8'hc9;
  localparam logic [7:0] signature_enable_op = 8'h0c;
  localparam logic [7:0] signature_disable_op = 8'h8d;
  localparam logic [7:0] clock_counter_select_op = 8'hce;
  localparam logic [7:0] clock_counter_enable_op = 8'h0f;
  localparam logic [7:0] clock_counter_disable_op = 8'h90;
  localparam logic [7:0] default_bypass_op = 8'h07;
  localparam logic [7:0] pass_through_port0_op = 8'ha0;

  // ---------------------------------------------------------------
  // selected data register
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    dr_idcode, dr_bypass, dr_mode0, dr_mode1, dr_mode2, dr_mode3,
    dr_group, dr_signature, dr_counter, dr_pass_through_port0_op
  } dr_sel_type;

  // control action of the current instruction
  typedef enum logic [3:0] {
    act_none, act_insert, act_park_reset, act_park_idle, act_park_pause,
    act_goto_wait, act_soft_reset, act_sig_on, act_sig_off,
    act_cnt_on, act_cnt_off
  } action_type;

  // tap controller states of the bridge end; the tester has its own sequencer
  typedef enum logic [3:0] {
    tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_shift_dr, tap_exit1_dr,
    tap_pause_dr, tap_exit2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir,
    tap_shift_ir, tap_exit1_ir, tap_pause_ir, tap_exit2_ir, tap_upd_ir
  } tap_state_type;

  function automatic tap_state_type tap_next(input tap_state_type s,
                                             input logic tms);
    case (s)
      tap_reset: tap_next = tms ? tap_reset : tap_idle;
      tap_idle: tap_next = tms ? tap_sel_dr : tap_idle;
      tap_sel_dr: tap_next = tms ? tap_sel_ir : tap_cap_dr;
      tap_cap_dr: tap_next = tms ? tap_exit1_dr : tap_shift_dr;
      tap_shift_dr: tap_next = tms ? tap_exit1_dr : tap_shift_dr;
      tap_exit1_dr: tap_next = tms ? tap_upd_dr : tap_pause_dr;
      tap_pause_dr: tap_next = tms ? tap_exit2_dr : tap_pause_dr;
      tap_exit2_dr: tap_next = tms ? tap_upd_dr : tap_shift_dr;
      tap_upd_dr: tap_next = tms ? tap_sel_dr : tap_idle;
      tap_sel_ir: tap_next = tms ? tap_reset : tap_cap_ir;
      tap_cap_ir: tap_next = tms ? tap_exit1_ir : tap_shift_ir;
      tap_shift_ir: tap_next = tms ? tap_exit1_ir : tap_shift_ir;
      tap_exit1_ir: tap_next = tms ? tap_upd_ir : tap_pause_ir;
      tap_pause_ir: tap_next = tms ? tap_exit2_ir : tap_pause_ir;
      tap_exit2_ir: tap_next = tms ? tap_upd_ir : tap_shift_ir;
      tap_upd_ir: tap_next = tms ? tap_sel_dr : tap_idle;
      default: tap_next = tap_reset;
    endcase
  endfunction : tap_next

endpackage : scan_op_pkg

// *** include/scan_link_if.sv ***
// backplane test link between tester and bridge decoder
// assumes: test clock is sys_clk on both ends, tdo resolved by enable
`timescale 1ns/1ps
interface scan_link_if;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_line;

  // pulled high when no one drives the shared line
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

  modport device (input tms, input tdi, output tdo, output tdo_oe_n);
  modport tester (output tms, output tdi, input tdo_line);
endinterface : scan_link_if

// *** rtl/scan_tester.sv ***
// tester end: loads one instruction or scans one data word over the link
// assumes: link tdo_line comes from the bridge on the same clock
`timescale 1ns/1ps
module scan_tester #(
  parameter int unsigned dr_len_max = 32
) (
  input wire logic sys_clk,
  input wire logic reset,
  scan_link_if.tester link,
  input wire logic start,
  input wire logic is_ir,
  input wire logic [31:0] data_in,
  input wire logic [5:0] length,
  input wire logic go_reset,
  output logic busy,
  output logic done,
  output logic [31:0] data_out
);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum {
    st_reset, st_idle, st_sel_dr, st_sel_ir, st_cap, st_shift, st_exit,
    st_upd
  } seq_type;

  seq_type st_q, st_d;
  logic [2:0] rcnt_q, rcnt_d;
  logic [31:0] sh_q, sh_d, out_q, out_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] rx_q, rx_d, rx_next;
  logic [5:0] len_q, len_d;
  // tms and tdo are both registered, so replies trail a shift by two edges
  logic v1_q, v1_d, v2_q, v2_d;
  logic ir_q, ir_d, tms_q, tms_d, tdi_q, tdi_d, done_q, done_d, busy_q, busy_d;

  always_comb begin
    st_d = st_q;
    rcnt_d = rcnt_q;
    sh_d = sh_q;
    out_d = out_q;
    cnt_d = cnt_q;
    len_d = len_q;
    v1_d = (st_q == st_shift);
    v2_d = v1_q;
    rx_next = v2_q ? {link.tdo_line, rx_q[31:1]} : rx_q;
    rx_d = rx_next;
    ir_d = ir_q;
    tms_d = 1'b0;
    tdi_d = tdi_q;
    done_d = 1'b0;
    busy_d = 1'b1;
    case (st_q)
      st_reset: begin
        // five tms highs reach test-logic-reset from any state
        tms_d = 1'b1;
        rcnt_d = rcnt_q + 3'h1;
        if (rcnt_q == 3'h4) begin
          tms_d = 1'b0;
          st_d = st_idle;
        end
      end
      st_idle: begin
        busy_d = 1'b0;
        if (go_reset) begin
          rcnt_d = 3'h0;
          tms_d = 1'b1;
          busy_d = 1'b1;
          st_d = st_reset;
        end else if (start) begin
          sh_d = data_in;
          cnt_d = (length > 6'(dr_len_max)) ? 6'(dr_len_max) : length;
          len_d = cnt_d;
          ir_d = is_ir;
          tms_d = 1'b1;
          busy_d = 1'b1;
          st_d = st_sel_dr;
        end
      end
      st_sel_dr: begin
        tms_d = ir_q;
        st_d = ir_q ? st_sel_ir : st_cap;
      end
      st_sel_ir: st_d = st_cap;
      st_cap: st_d = st_shift;
      st_shift: begin
        // the bridge enters shift one edge after us, so bit 0 goes out here
        tdi_d = sh_q[0];
        sh_d = sh_q >> 1;
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          tms_d = 1'b1;
          st_d = st_exit;
        end
      end
      st_exit: begin
        tms_d = 1'b1;
        st_d = st_upd;
      end
      st_upd: begin
        // the last reply bit arrives at this edge; right-justify the word
        out_d = rx_next >> (6'h20 - len_q);
        done_d = 1'b1;
        st_d = st_idle;
      end
      default: st_d = st_reset;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q <= st_reset;
      rcnt_q <= 3'h0;
      sh_q <= 32'h00000000;
      out_q <= 32'h00000000;
      cnt_q <= 6'h00;
      rx_q <= 32'h00000000;
      len_q <= 6'h00;
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      ir_q <= 1'b0;
      tms_q <= 1'b1;
      tdi_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      rcnt_q <= rcnt_d;
      sh_q <= sh_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      len_q <= len_d;
      v1_q <= v1_d;
      v2_q <= v2_d;
      ir_q <= ir_d;
      tms_q <= tms_d;
      tdi_q <= tdi_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign link.tms = tms_q;
  assign link.tdi = tdi_q;
  assign busy = busy_q;
  assign done = done_q;
  assign data_out = out_q;

endmodule : scan_tester

// *** testbench/scan_decoder_monitor.sv ***
// concurrent checks on the test link and the decoder's decode outputs
// assumes: one clock domain, instantiated beside the link interface
`timescale 1ns/1ps
module scan_decoder_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tdo_oe_n,
  input wire logic tdo_line,
  input wire logic selected,
  input wire logic multicast_mode,
  input wire scan_op_pkg::dr_sel_type dr_select,
  input wire scan_op_pkg::action_type action,
  input wire logic action_pulse,
  input wire logic [7:0] instruction,
  input wire logic test_reset
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  sequence s_unselected;
    !selected [*3];
  endsequence

  sequence s_grouped;
    multicast_mode [*2];
  endsequence

  // selected for three cycles, no update and no tap reset just before
  sequence s_quiet;
    selected [*3] ##0 (!action_pulse && !test_reset && !$past(test_reset));
  endsequence

  property p_decode(logic [7:0] op, scan_op_pkg::dr_sel_type d);
    action_pulse && instruction == op |-> dr_select == d;
  endproperty

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_insert_decode: assert property (
    action_pulse && instruction == scan_op_pkg::insert_local_ports_op |->
      action == scan_op_pkg::act_insert &&
      dr_select == scan_op_pkg::dr_idcode)
    else $error("insert opcode decoded wrongly");
  a_mode0_decode: assert property (
    p_decode(scan_op_pkg::mode_reg0_select_op, scan_op_pkg::dr_mode0))
    else $error("mode register zero not selected");
  a_counter_decode: assert property (
    p_decode(scan_op_pkg::clock_counter_select_op, scan_op_pkg::dr_counter))
    else $error("clock counter not selected");
  a_bypass_decode: assert property (
    p_decode(scan_op_pkg::default_bypass_op, scan_op_pkg::dr_bypass))
    else $error("bypass not selected");
  a_control_idcode: assert property (
    action_pulse && action != scan_op_pkg::act_none |->
      dr_select == scan_op_pkg::dr_idcode)
    else $error("control opcode left idcode out of path");
  a_unselected_quiet: assert property (
    s_unselected |-> !action_pulse)
    else $error("opcode acted on while not selected");
  a_group_floats: assert property (
    s_grouped |-> tdo_oe_n)
    else $error("test output driven in group mode");
  a_released_high: assert property (
    tdo_oe_n |-> tdo_line)
    else $error("released line not high");
  a_select_holds: assert property (
    s_quiet |-> $stable(dr_select))
    else $error("data register changed without update");
  a_tap_reset_idcode: assert property (
    test_reset |=> dr_select == scan_op_pkg::dr_idcode &&
      action == scan_op_pkg::act_none)
    else $error("tap reset did not restore idcode");
  a_pulse_single: assert property (
    action_pulse |=> !action_pulse)
    else $error("action pulse longer than one cycle");
endmodule : scan_decoder_monitor

// *** testbench/multidrop_scan_bridge_opcode_decoder_test.sv ***
// self-checking bench: tester end drives the bridge end over the link
// assumes: tester holds busy until idle, mode registers read as zero
`timescale 1ns/1ps
`define check_eq(got, exp, msg) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %0t %s", $time, msg); \
    end \
  end
module multidrop_scan_bridge_opcode_decoder_test;
  localparam scan_op_pkg::dr_sel_type id_sel = scan_op_pkg::dr_idcode;
  localparam scan_op_pkg::action_type no_act = scan_op_pkg::act_none;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic selected = 1'b1;
  logic multicast_mode = 1'b0;
  logic dr_tdo_in = 1'b0;
  logic start = 1'b0;
  logic is_ir = 1'b0;
  logic go_reset = 1'b0;
  logic [31:0] data_in = 32'h0;
  logic [5:0] length = 6'h08;
  logic busy;
  logic done;
  logic [31:0] data_out;
  scan_op_pkg::dr_sel_type dr_select;
  scan_op_pkg::action_type action;
  logic action_pulse;
  logic [7:0] instruction;
  logic test_reset;
  logic capture_dr;
  logic shift_dr;
  logic update_dr;
  int dr_shifts;
  int dr_caps;
  int dr_upds;
  int n_mismatch = 0;
  int n_compared = 0;

  // ---------------------------------------------------------------
  // ends, link and checker
  // ---------------------------------------------------------------
  scan_link_if i_scan_link_if ();
  scan_opcode_decoder i_scan_opcode_decoder (.sys_clk(sys_clk),
    .reset(reset), .link(i_scan_link_if), .selected(selected),
    .multicast_mode(multicast_mode), .dr_tdo_in(dr_tdo_in),
    .dr_select(dr_select), .action(action), .action_pulse(action_pulse),
    .instruction(instruction), .capture_dr(capture_dr),
    .shift_dr(shift_dr), .update_dr(update_dr),
    .test_reset(test_reset));
  scan_tester i_scan_tester (.sys_clk(sys_clk), .reset(reset),
    .link(i_scan_link_if), .start(start), .is_ir(is_ir), .data_in(data_in),
    .length(length), .go_reset(go_reset), .busy(busy), .done(done),
    .data_out(data_out));
  scan_decoder_monitor i_scan_decoder_monitor (.sys_clk(sys_clk),
    .reset(reset), .tdo_oe_n(i_scan_link_if.tdo_oe_n),
    .tdo_line(i_scan_link_if.tdo_line), .selected(selected),
    .multicast_mode(multicast_mode), .dr_select(dr_select),
    .action(action), .action_pulse(action_pulse),
    .instruction(instruction), .test_reset(test_reset));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    `check_eq(busy, 1'b0, "tester never went idle")
  endtask : wait_idle

  task automatic scan(input logic ir, input logic [31:0] din,
                      input logic [5:0] len, output logic [31:0] dout);
    int k;
    wait_idle();
    is_ir <= ir;
    data_in <= din;
    length <= len;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    k = 0;
    dr_shifts = 0;
    dr_caps = 0;
    dr_upds = 0;
    while (done !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      k++;
      dr_shifts += int'(shift_dr === 1'b1);
      dr_caps += int'(capture_dr === 1'b1);
      dr_upds += int'(update_dr === 1'b1);
    end
    `check_eq(done, 1'b1, "scan never finished")
    dout = data_out;
    // let the decode registers settle after update
    repeat (2) @(posedge sys_clk);
  endtask : scan

  task automatic run_op(input logic [7:0] op,
                        input scan_op_pkg::dr_sel_type d,
                        input scan_op_pkg::action_type a);
    logic [31:0] got;
    logic [31:0] exp;
    logic [31:0] mask;
    logic [5:0] len;
    scan(1'b1, {24'h0, op}, 6'h08, got);
    `check_eq(got[7:0], scan_op_pkg::ir_capture_value, "ir capture")
    `check_eq(dr_shifts, 0, "ir scan shifted a data register")
    `check_eq(instruction, op, "opcode not latched")
    `check_eq(dr_select, d, "wrong data register")
    `check_eq(action, a, "wrong control action")
    len = (d == id_sel) ? 6'h20 : 6'h08;
    mask = (d == id_sel) ? 32'hffffffff : 32'h000000ff;
    exp = (d == scan_op_pkg::dr_bypass) ? 32'h000000fe : 32'h0;
    if (d == id_sel) exp = scan_op_pkg::idcode_value;
    scan(1'b0, 32'hffffffff, len, got);
    `check_eq(got & mask, exp, "data register read")
    `check_eq(dr_shifts, int'(len), "data shift cycles")
    `check_eq(dr_caps, 1, "data capture count")
    `check_eq(dr_upds, 1, "data update count")
    `check_eq(dr_select, d, "data scan moved selection")
  endtask : run_op

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic check_reset_state();
    wait_idle();
    `check_eq(dr_select, id_sel, "reset selection")
    `check_eq(action, no_act, "reset action")
    `check_eq(instruction, scan_op_pkg::ir_reset_value, "reset ir")
  endtask : check_reset_state

  task automatic check_opcode_table();
    run_op(8'he7, id_sel, scan_op_pkg::act_insert);
    run_op(8'hc5, id_sel, scan_op_pkg::act_park_reset);
    run_op(8'h84, id_sel, scan_op_pkg::act_park_idle);
    run_op(8'hc6, id_sel, scan_op_pkg::act_park_pause);
    run_op(8'hc3, id_sel, scan_op_pkg::act_goto_wait);
    run_op(8'h8e, scan_op_pkg::dr_mode0, no_act);
    run_op(8'h82, scan_op_pkg::dr_mode1, no_act);
    run_op(8'h83, scan_op_pkg::dr_mode2, no_act);
    run_op(8'h85, scan_op_pkg::dr_mode3, no_act);
    run_op(8'h03, scan_op_pkg::dr_group, no_act);
    run_op(8'h88, id_sel, scan_op_pkg::act_soft_reset);
    run_op(8'hc9, scan_op_pkg::dr_signature, no_act);
    run_op(8'h0c, id_sel, scan_op_pkg::act_sig_on);
    run_op(8'h8d, id_sel, scan_op_pkg::act_sig_off);
    run_op(8'hce, scan_op_pkg::dr_counter, no_act);
    run_op(8'h0f, id_sel, scan_op_pkg::act_cnt_on);
    run_op(8'h90, id_sel, scan_op_pkg::act_cnt_off);
    run_op(8'h07, scan_op_pkg::dr_bypass, no_act);
    run_op(8'ha0, scan_op_pkg::dr_pass_through_port0_op, no_act);
    run_op(8'ha1, id_sel, no_act);
    run_op(8'h55, id_sel, no_act);
  endtask : check_opcode_table

  task automatic check_unselected();
    logic [31:0] got;
    selected <= 1'b0;
    scan(1'b1, 32'h0000008e, 6'h08, got);
    `check_eq(instruction, 8'h8e, "ir not latched")
    `check_eq(dr_select, id_sel, "acted while unselected")
    `check_eq(action, no_act, "action while unselected")
    selected <= 1'b1;
    @(posedge sys_clk);
  endtask : check_unselected

  task automatic check_tap_reset();
    run_op(8'hce, scan_op_pkg::dr_counter, no_act);
    go_reset <= 1'b1;
    @(posedge sys_clk);
    go_reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wait_idle();
    `check_eq(dr_select, id_sel, "tap reset selection")
    `check_eq(instruction, scan_op_pkg::ir_reset_value, "tap reset ir")
  endtask : check_tap_reset

  task automatic check_group_float();
    logic [31:0] got;
    multicast_mode <= 1'b1;
    scan(1'b1, 32'h000000aa, 6'h08, got);
    `check_eq(got[7:0], 8'hff, "ir scan driven in group")
    scan(1'b0, 32'h0, 6'h20, got);
    `check_eq(got, 32'hffffffff, "dr scan driven in group")
    multicast_mode <= 1'b0;
    @(posedge sys_clk);
  endtask : check_group_float

  // ---------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // a full run is forty-seven scans of under fifty cycles each
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    check_reset_state();
    check_opcode_table();
    check_unselected();
    check_tap_reset();
    check_group_float();
    test_done();
  end
endmodule : multidrop_scan_bridge_opcode_decoder_test
